// ===== logic/adc_cfg_defines.svh
// Constants of the ADC configuration serial port: offsets, fields, counts.
// Assumes inclusion by its bare name wherever the macros are used.
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

`define SAMPLE_W          14
`define CHAN_N            4
`define ADDR_SOFT_RESET   7'h00
`define ADDR_FORMAT_POWER 7'h01
`define FMT_RESET         8'h00
`define SOFT_RESET_BIT    7
`define FMT_SCRAMBLE_BIT  6
`define FMT_SIGNED_BIT    5
`define FMT_SLEEP_BIT     4
`define CMD_RW_BIT        15
`define CMD_BITS          5'h10
`define HDR_BITS          5'h08
// Idle pin levels: chip select high, data out pulled up
`define PINS_IDLE         5'h09
// Serial-mode output settings live in a register not built here
`define SER_TWO_LANE      1'b1
`define SER_LOW_CURRENT   1'b0
`define SER_TERM_EN       1'b0

`endif

// ===== logic/adc_cfg_pkg.sv
// Types shared by the ADC configuration serial port.
// Assumes the defines header is on the include path.
`default_nettype none
`include "adc_cfg_defines.svh"

package adc_cfg_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HOLD  = 2'b10
  } xfer_state_t;

  typedef struct packed {
    logic strap;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo;
  } pins_t;

  typedef struct packed {
    logic       two_lane;
    logic       low_current;
    logic       term_en;
    logic       sleep;
    logic [3:0] nap;
    logic       output_scrambler_enable;
    logic       signed_format_select;
  } mode_t;

  typedef logic [`CHAN_N-1:0][`SAMPLE_W-1:0] samples_t;

  typedef struct packed {
    xfer_state_t st;
    logic [4:0]  cnt;
    logic [15:0] word;
    logic [7:0]  rd_sh;
    logic        rd_act;
    logic        sck_prev;
    logic [7:0]  fmt_reg;
    logic        sdo_oe;
    mode_t       mode;
    samples_t    data;
  } state_t;

endpackage

`default_nettype wire

// ===== logic/pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // Stage 0 feeds stage 1 and nothing else
  logic [1:0][W-1:0] stg_q;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    // Idle levels at reset, so no false edge follows its release
    if (rst_i)
      stg_q <= {2{RST_VAL}};
    else if (clk_en_i)
      stg_q <= {stg_q[0], async_i};
  end

  assign sync_o = stg_q[1];

endmodule // pin_sync

`default_nettype wire

// ===== logic/sample_format.sv
// Output number format and scrambler for one channel's sample.
// Assumes the raw sample is offset binary.
`timescale 1ns/100ps
`default_nettype none

module sample_format #(
  parameter int W = 14
) (
  input  wire logic [W-1:0] raw_i,
  input  wire logic         scramble_i,
  input  wire logic         signed_i,
  output logic      [W-1:0] fmt_o
);

  logic [W-1:0] v;

  always_comb
  begin
    v = raw_i;
    if (signed_i)
      v[W-1] = ~v[W-1];
    // Format first, so the receiver undoes the scrambler before the sign
    if (scramble_i)
      v[W-1:1] = v[W-1:1] ^ {(W-1){v[0]}};
    fmt_o = v;
  end

endmodule // sample_format

`default_nettype wire

// ===== logic/adc_cfg_port.sv
// Configuration serial port and strap decoding of a four-channel ADC.
// Assumes the pins are asynchronous; samples come on clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_defines.svh"

// Notes on behaviour
// - Strap low makes the four port pins a serial register port.
// - Every register access is one sixteen-bit command word.
// - Chip select low starts; data sampled on first sixteen rising edges.
// - Rising clock edges after the sixteenth are ignored until chip select rises.
// - Word is read/write flag, seven address bits, eight data bits.
// - Flag zero writes the eight data bits to the addressed register.
// - Flag one reads the register out, leaves it, ignores input data.
// - Serial output only pulls low or releases; host supplies pull-up.
// - Strap mode: chip select low two-lane 16-bit, high one-lane 14-bit.
// - Strap mode: clock low 3.5 mA drive, high 1.75 mA drive.
// - Strap mode: data in low normal, high puts device to sleep.
// - Strap mode: data out pin high enables internal termination.
// - Writing one to reset bit D7 clears all mode register bits.
// - The reset bit returns to zero by itself after the write.
// - Reset register bits six to zero are ignored.
// - Format register bit 6 switches the output scrambler.
// - Format register bit 5 selects two's complement over offset binary.
// - Bits four to zero zero is normal; bit four sleeps everything.
// - With sleep clear, bits zero to three nap channels one to four.
// - Scrambler XORs every data bit but the LSB with the LSB.
module adc_cfg_port
  import adc_cfg_pkg::*;
(
  input  wire logic     clk_sys_i,
  input  wire logic     rst_i,
  input  wire logic     clk_en_i,
  input  wire logic     interface_select_strap_i,
  input  wire logic     cs_n_i,
  input  wire logic     sck_i,
  input  wire logic     sdi_i,
  input  wire logic     sdo_i,
  output logic          sdo_o,
  output logic          sdo_oe_o,
  input  wire samples_t chan_sample_i,
  output mode_t         mode_o,
  output samples_t      chan_data_o
);

  state_t   q;
  state_t   d;
  pins_t    pin_raw;
  pins_t    p;
  samples_t fmt_data;
  logic     ser_mode;
  logic     sck_rise;
  logic     sck_fall;
  logic     rw_flag;
  logic [6:0] addr;
  logic [4:0] cnt_inc;
  logic [15:0] word_in;

  assign pin_raw = '{strap: interface_select_strap_i, cs_n: cs_n_i,
                     sck: sck_i, sdi: sdi_i, sdo: sdo_i};

  pin_sync #(
    .W       ($bits(pins_t)),
    .RST_VAL (`PINS_IDLE)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (pin_raw),
    .sync_o    (p)
  );

  for (genvar i = 0; i < `CHAN_N; i++)
  begin : g_fmt
    sample_format #(
      .W (`SAMPLE_W)
    ) u_fmt (
      .raw_i      (chan_sample_i[i]),
      .scramble_i (q.mode.output_scrambler_enable),
      .signed_i   (q.mode.signed_format_select),
      .fmt_o      (fmt_data[i])
    );
  end

  assign ser_mode = ~p.strap;
  assign sck_rise = p.sck & ~q.sck_prev;
  assign sck_fall = ~p.sck & q.sck_prev;
  assign cnt_inc  = q.cnt + 5'h01;
  assign word_in  = {q.word[14:0], p.sdi};
  assign rw_flag  = q.word[`CMD_RW_BIT];
  assign addr     = q.word[14:8];

  always_comb
  begin
    d          = q;
    d.sck_prev = p.sck;
    case (q.st)
      ST_IDLE:
      begin
        d.rd_act = 1'b0;
        d.cnt    = 5'h00;
        if (ser_mode && !p.cs_n)
          d.st = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (p.cs_n)
        begin
          d.st     = ST_IDLE;
          d.rd_act = 1'b0;
        end
        else if (sck_rise)
        begin
          d.word = word_in;
          d.cnt  = cnt_inc;
          if (cnt_inc == `CMD_BITS)
            d.st = ST_HOLD;
          // Header complete: flag now in bit 7, address below it
          if (cnt_inc == `HDR_BITS && word_in[7])
          begin
            d.rd_act = 1'b1;
            d.rd_sh  = (word_in[6:0] == `ADDR_FORMAT_POWER) ?
                       q.fmt_reg : 8'h00;
          end
        end
        else if (sck_fall && q.rd_act && q.cnt > `HDR_BITS)
          d.rd_sh = {q.rd_sh[6:0], 1'b0};
      end
      ST_HOLD:
      begin
        // Extra rising edges land here and change nothing; falling edges still shift a readback
        if (sck_fall && q.rd_act)
          d.rd_sh = {q.rd_sh[6:0], 1'b0};
        if (p.cs_n)
        begin
          d.st     = ST_IDLE;
          d.rd_act = 1'b0;
          if (!rw_flag)
          begin
            if (addr == `ADDR_SOFT_RESET && q.word[`SOFT_RESET_BIT])
              d.fmt_reg = `FMT_RESET;
            else if (addr == `ADDR_FORMAT_POWER)
              d.fmt_reg = q.word[7:0];
          end
        end
      end
      default:
      begin
        d.st     = ST_IDLE;
        d.rd_act = 1'b0;
      end
    endcase
    if (!ser_mode)
    begin
      d.st     = ST_IDLE;
      d.rd_act = 1'b0;
    end
    d.sdo_oe = d.rd_act & ~d.rd_sh[7];

    if (ser_mode)
    begin
      d.mode.two_lane    = `SER_TWO_LANE;
      d.mode.low_current = `SER_LOW_CURRENT;
      d.mode.term_en     = `SER_TERM_EN;
      d.mode.sleep       = q.fmt_reg[`FMT_SLEEP_BIT];
      d.mode.nap         = q.fmt_reg[`FMT_SLEEP_BIT] ? 4'h0 :
                           q.fmt_reg[3:0];
      d.mode.output_scrambler_enable = q.fmt_reg[`FMT_SCRAMBLE_BIT];
      d.mode.signed_format_select    = q.fmt_reg[`FMT_SIGNED_BIT];
    end
    else
    begin
      d.mode.two_lane    = ~p.cs_n;
      d.mode.low_current = p.sck;
      d.mode.sleep       = p.sdi;
      d.mode.term_en     = p.sdo;
      d.mode.nap         = 4'h0;
      d.mode.output_scrambler_enable = 1'b0;
      d.mode.signed_format_select    = 1'b0;
    end

    for (int i = 0; i < `CHAN_N; i++)
      d.data[i] = (q.mode.sleep || q.mode.nap[i]) ? '0 : fmt_data[i];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.fmt_reg <= `FMT_RESET;
    end
    else if (clk_en_i)
      q <= d;
  end

  // Open drain: the driven level is always low
  assign sdo_o       = 1'b0;
  assign sdo_oe_o    = q.sdo_oe;
  assign mode_o      = q.mode;
  assign chan_data_o = q.data;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  open_drain_a: assert property (
    sdo_oe_o |-> (q.rd_act && q.rd_sh[7] == 1'b0))
    else $error("Serial output pulled low outside a readback zero");

  xfer_start_a: assert property (
    (clk_en_i && q.st == ST_IDLE && ser_mode && !p.cs_n)
      |=> (q.st == ST_SHIFT && q.cnt == 5'h00))
    else $error("Transfer did not start on chip select low");

  sixteen_edges_a: assert property (
    (clk_en_i && q.st == ST_SHIFT && !p.cs_n && ser_mode && sck_rise
      && q.cnt == 5'h0f) |=> (q.st == ST_HOLD && q.cnt == 5'h10))
    else $error("Sixteenth edge did not end capture");

  hold_ignore_a: assert property (
    (q.st == ST_HOLD && !p.cs_n) |=> $stable(q.word))
    else $error("Word changed after sixteen edges");

  write_commit_a: assert property (
    (clk_en_i && q.st == ST_HOLD && p.cs_n && ser_mode && !rw_flag
      && addr == 7'h01) |=> q.fmt_reg == $past(q.word[7:0]))
    else $error("Write to format register lost");

  soft_reset_a: assert property (
    (clk_en_i && q.st == ST_HOLD && p.cs_n && ser_mode && !rw_flag
      && addr == 7'h00 && q.word[7]) |=> (q.fmt_reg == 8'h00)
      ##1 (q.fmt_reg == 8'h00 || $changed(q.word)))
    else $error("Software reset did not clear the register");

  read_keep_a: assert property (
    (q.st == ST_HOLD && p.cs_n && rw_flag) |=> $stable(q.fmt_reg))
    else $error("Read command changed a register");

  partial_drop_a: assert property (
    (q.st == ST_SHIFT && p.cs_n) |=> ($stable(q.fmt_reg) [*2]))
    else $error("Partial word changed a register");

  strap_map_a: assert property (
    (clk_en_i && p.strap) |=> (mode_o.sleep == $past(p.sdi)
      && mode_o.two_lane == !$past(p.cs_n)
      && mode_o.term_en == $past(p.sdo)))
    else $error("Strap pins not mapped onto the modes");

  sleep_nap_a: assert property (
    (clk_en_i && ser_mode) |=> (mode_o.sleep == $past(q.fmt_reg[4])
      && mode_o.nap == ($past(q.fmt_reg[4]) ? 4'h0 : $past(q.fmt_reg[3:0]))))
    else $error("Sleep or nap bits not applied");

  read_start_a: assert property (
    (clk_en_i && q.st == ST_SHIFT && !p.cs_n && ser_mode && sck_rise
      && q.cnt == 5'h07 && word_in[7]) |=> q.rd_act)
    else $error("Read command did not arm the readback");

  reset_reads_zero_a: assert property (
    (clk_en_i && q.st == ST_SHIFT && !p.cs_n && ser_mode && sck_rise
      && q.cnt == 5'h07 && word_in[7] && word_in[6:0] == 7'h00)
      |=> (q.rd_sh == 8'h00))
    else $error("Reset register did not read back as zero");

  reset_dont_care_a: assert property (
    (clk_en_i && q.st == ST_HOLD && p.cs_n && ser_mode && !rw_flag
      && addr == 7'h00 && !q.word[7]) |=> $stable(q.fmt_reg))
    else $error("Reset register low bits had an effect");

  hold_count_a: assert property (
    (clk_en_i && q.st == ST_HOLD && !p.cs_n && ser_mode)
      |=> (q.cnt == 5'h10))
    else $error("Edge count moved after sixteen edges");

  readback_shift_a: assert property (
    (clk_en_i && q.st == ST_SHIFT && !p.cs_n && ser_mode && sck_fall
      && q.rd_act && q.cnt > 5'h08)
      |=> (q.rd_sh == {$past(q.rd_sh[6:0]), 1'b0}))
    else $error("Readback data did not advance one bit");

  scramble_map_a: assert property (
    (clk_en_i && ser_mode)
      |=> (mode_o.output_scrambler_enable == $past(q.fmt_reg[6])))
    else $error("Scrambler enable not taken from the register");

  format_map_a: assert property (
    (clk_en_i && ser_mode)
      |=> (mode_o.signed_format_select == $past(q.fmt_reg[5])))
    else $error("Number format not taken from the register");

  sleep_blank_a: assert property (
    (clk_en_i && q.mode.sleep) |=> (chan_data_o == '0))
    else $error("Channel data not blanked in sleep");

  current_strap_a: assert property (
    (clk_en_i && p.strap) |=> (mode_o.low_current == $past(p.sck)))
    else $error("Clock strap not mapped onto drive current");

  idle_release_a: assert property (
    (clk_en_i && q.st == ST_IDLE) |=> !sdo_oe_o)
    else $error("Serial output held low outside a transfer");

endmodule // adc_cfg_port

`default_nettype wire

// ===== dv/spi_host_model.sv
// Host side of the configuration port: serial master and SDO pull-up.
// Assumes the caller spaces transfers; link clock is 125 ns.
// High 65 ns, low 60 ns: every change lands on a falling system edge.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o,
  input  wire logic sdo_oe_i,
  output logic      sdo_o
);
  logic pull_lvl = 1'b1;

  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // Open-drain wire: pulled to pull_lvl unless the device sinks it
  assign sdo_o = sdo_oe_i ? 1'b0 : pull_lvl;

  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    #60;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = (i < 16) ? w[15 - i] : ~sdi_o;
      #60;
      sck_o = 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo_o};
      #65;
      sck_o = 1'b0;
    end
    #60;
    cs_n_o = 1'b1;
    // Released data line must not keep the last bit
    sdi_o = ~sdi_o;
    #60;
  endtask

  task automatic strap(input logic [3:0] v);
    {cs_n_o, sck_o, sdi_o, pull_lvl} = v;
  endtask
endmodule // spi_host_model

`default_nettype wire

// ===== dv/adc_config_serial_port_tb_top.sv
// Self-checking bench of the ADC configuration serial port.
// Assumes the host model drives the link; bench drives at falling edges.
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_defines.svh"

module adc_config_serial_port_tb_top
  import adc_cfg_pkg::*;
;
  logic     clk_sys_i = 1'b0;
  logic     rst_i     = 1'b1;
  logic     strap     = 1'b0;
  samples_t smp = {14'h1235, 14'h3ffe, 14'h2000, 14'h0001};
  logic     cs_n, sck, sdi, sdo_w, sdo_drv, sdo_oe;
  mode_t    mode;
  samples_t dout;
  logic [7:0] rdv;
  int       failures = 0;
  int       compares = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  spi_host_model host (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
                       .sdo_oe_i(sdo_oe), .sdo_o(sdo_w));

  adc_cfg_port dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .clk_en_i(1'b1), .interface_select_strap_i(strap), .cs_n_i(cs_n),
    .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_w), .sdo_o(sdo_drv),
    .sdo_oe_o(sdo_oe), .chan_sample_i(smp), .mode_o(mode),
    .chan_data_o(dout));

  task automatic report(input logic [55:0] got, input logic [55:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    report({48'h0, got}, {48'h0, exp});
  endtask

  task automatic chk_out(input logic [55:0] got, input logic [55:0] exp);
    report(got, exp);
  endtask

  function automatic mode_t exp_mode(input logic [7:0] r);
    exp_mode = {`SER_TWO_LANE, `SER_LOW_CURRENT, `SER_TERM_EN, r[4],
                r[4] ? 4'h0 : r[3:0], r[6], r[5]};
  endfunction

  // Sign flip first, then every bit above the LSB XORed with the LSB
  function automatic samples_t exp_data(input logic [7:0] r);
    logic [13:0] v;
    exp_data = '0;
    for (int i = 0; i < `CHAN_N; i++)
    begin
      v = smp[i] ^ {r[5], 13'h0000};
      if (r[6]) v[13:1] = v[13:1] ^ {13{v[0]}};
      if (!r[4] && !r[i]) exp_data[i] = v;
    end
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    host.xfer({1'b0, a, d}, n, rdv);
    repeat (12) @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] junk,
                    input logic [7:0] exp);
    host.xfer({1'b1, a, junk}, 16, rdv);
    chk_reg(rdv, exp);
  endtask

  task automatic post(input logic [7:0] r);
    chk_out({46'h0, mode}, {46'h0, exp_mode(r)});
    chk_out(dout, exp_data(r));
  endtask

  task automatic summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #400000;
    failures++;
    summarize();
  end

  initial
  begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk_reg({sdo_drv, sdo_oe, 6'h00}, 8'h00);
    wr(7'h00, 8'h80, 16);
    rd(7'h01, 8'h00, 8'h00);
    wr(7'h01, 8'h60, 16);
    post(8'h60);
    rd(7'h01, 8'hff, 8'h60);
    rd(7'h01, 8'h00, 8'h60);
    wr(7'h01, 8'h05, 19);
    rd(7'h01, 8'h00, 8'h05);
    post(8'h05);
    wr(7'h01, 8'h1a, 10);
    rd(7'h01, 8'h00, 8'h05);
    wr(7'h01, 8'h1f, 16);
    post(8'h1f);
    wr(7'h01, 8'h0a, 16);
    post(8'h0a);
    wr(7'h00, 8'h7f, 16);
    rd(7'h01, 8'h00, 8'h0a);
    wr(7'h05, 8'h33, 16);
    rd(7'h01, 8'h00, 8'h0a);
    rd(7'h05, 8'h00, 8'h00);
    wr(7'h00, 8'hff, 16);
    rd(7'h01, 8'h00, 8'h00);
    post(8'h00);
    rd(7'h00, 8'h00, 8'h00);
    @(negedge clk_sys_i);
    strap = 1'b1;
    for (int v = 0; v < 16; v++)
    begin
      host.strap(v[3:0]);
      repeat (8) @(negedge clk_sys_i);
      chk_out({46'h0, mode}, {46'h0, ~v[3], v[2], v[0], v[1], 6'h00});
    end
    summarize();
  end
endmodule // adc_config_serial_port_tb_top

`default_nettype wire
